//--- ccdp_delay.sv
// fixed-depth delay line for a data word
`timescale 1ns/1ps
module ccdp_delay #(
  parameter int W = 8,
  parameter int D = 1
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] stage_r [D];
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < D; i++) stage_r[i] <= '0;
    end else begin
      stage_r[0] <= d_i;
      for (int i = 1; i < D; i++) stage_r[i] <= stage_r[i-1];
    end
  end
  assign q_o = stage_r[D-1];
endmodule

//--- ccdp_pkg.sv
// types shared by the correction sequencer
package ccdp_pkg;
  typedef enum logic [1:0] {
    CCDP_RED = 2'b00,
    CCDP_GREEN = 2'b01,
    CCDP_BLUE = 2'b10
  } ccdp_colour_e;
  typedef enum logic [2:0] {
    CCDP_3CH_CDS = 3'h0,
    CCDP_3CH_SHA = 3'h1,
    CCDP_1CH_CDS = 3'h2,
    CCDP_1CH_SHA = 3'h3,
    CCDP_BAYER = 3'h4
  } ccdp_mode_e;
  typedef struct packed {
    logic [11:0] gain;
    logic [9:0] offset;
  } ccdp_words_s;
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic [2:0] addr;
  } ccdp_host_s;
endpackage

//--- ccdp_regs.svh
// register addresses, field positions, reset values and latency counts
`ifndef CCDP_REGS_SVH
`define CCDP_REGS_SVH
`define CCDP_ADDR_CFG 3'h0
`define CCDP_ADDR_CFG2 3'h1
`define CCDP_ADDR_ODD 3'h3
`define CCDP_ADDR_EVEN 3'h4
`define CCDP_CFG_SCALE_LSB 0
`define CCDP_CFG_PINS_LSB 3
`define CCDP_CFG_PTR_LSB 6
`define CCDP_CFG_RST 8'h00
`define CCDP_CFG2_RST 8'h00
`define CCDP_CFG2_CDS_BIT 0
`define CCDP_CFG2_MONO_BIT 1
`define CCDP_TRIM_RST 8'h00
`define CCDP_LAT_SAMPLE 6
`define CCDP_LAT_WORDS 9
`define CCDP_ADC_W 12
`define CCDP_FULL 12'hfff
`endif

//--- ccdp_scanner_model.sv
// scanner controller model: line timing, converter result and pixel words
`timescale 1ns/1ps
module ccdp_scanner_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // values asked for by the bench
  input wire logic line_i,
  input wire logic [11:0] conv_i,
  input wire ccdp_pkg::ccdp_words_s words_i,
  // pins toward the sequencer
  output logic line_start_o,
  output logic [11:0] conv_data_o,
  output ccdp_pkg::ccdp_words_s words_o
);
  import ccdp_pkg::*;
  // change only just after an edge so every rising edge sees a settled word
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_start_o <= 1'b0;
      conv_data_o <= 12'h000;
      words_o <= '0;
    end else begin
      line_start_o <= line_i;
      // converter word stands for the sample taken by the sample clocks
      conv_data_o <= conv_i;
      words_o <= words_i;
    end
  end
endmodule

//--- ccdp_sequencer.sv
// pixel correction sequencer: colour sequencing, odd/even trim, offset, gain, host port
`timescale 1ns/1ps
`include "ccdp_regs.svh"
module ccdp_sequencer (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // converter and line timing
  input wire logic [11:0] conv_data_i,
  input wire logic line_start_i,
  // pixel-rate correction words
  input wire ccdp_pkg::ccdp_words_s words_i,
  // host strobes and address pins
  input wire ccdp_pkg::ccdp_host_s host_i,
  // shared output / host register data bus
  input wire logic [7:0] host_register_data_i,
  output logic [11:0] dout_o,
  output logic [11:0] dout_oe_o,
  // current mux channel and mode
  output logic [1:0] mux_sel_o,
  output logic [2:0] mode_o
);
  import ccdp_pkg::*;

  localparam int LW = `CCDP_LAT_WORDS - `CCDP_LAT_SAMPLE;

  // pin inputs other than the converter word pass two flops before use
  logic line_start_s;
  ccdp_host_s host_s;
  logic [7:0] wdata_s;
  ccdp_words_s words_s;
  ccdp_sync #(.W(1)) u_sync_line (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .d_i(line_start_i), .q_o(line_start_s));
  ccdp_sync #(.W(6)) u_sync_host (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .d_i(host_i), .q_o(host_s));
  ccdp_sync #(.W(8)) u_sync_wdata (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .d_i(host_register_data_i),
    .q_o(wdata_s));
  // words captured each edge; the sync stages count toward the fixed word latency
  ccdp_sync #(.W(22)) u_sync_words (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .d_i(words_i), .q_o(words_s));

  // host registers
  logic [7:0] cfg_r;
  logic [7:0] cfg2_r;
  logic [7:0] odd_pixel_offset_trim_r [3];
  logic [7:0] even_pixel_offset_trim_r [3];
  logic [3:0] wr_hist_r;

  wire host_sel = !host_s.cs_n;
  wire wr_act = host_sel && !host_s.wr_n;
  wire rd_act = host_sel && !host_s.rd_n;
  // write waits until the bus is released and the host's data has crossed the synchroniser
  wire wr_pulse = wr_act && wr_hist_r[2] && !wr_hist_r[3];
  wire [1:0] ptr = cfg_r[`CCDP_CFG_PTR_LSB +: 2];
  wire ptr_ok = (ptr != 2'b11);
  wire wr_cfg = wr_pulse && (host_s.addr == `CCDP_ADDR_CFG);
  wire wr_cfg2 = wr_pulse && (host_s.addr == `CCDP_ADDR_CFG2);
  wire wr_odd = wr_pulse && (host_s.addr == `CCDP_ADDR_ODD) && ptr_ok;
  wire wr_even = wr_pulse && (host_s.addr == `CCDP_ADDR_EVEN) && ptr_ok;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_hist_r <= 4'h0;
      cfg_r <= `CCDP_CFG_RST;
      cfg2_r <= `CCDP_CFG2_RST;
    end else begin
      wr_hist_r <= {wr_hist_r[2:0], wr_act};
      if (wr_cfg) cfg_r <= wdata_s;
      if (wr_cfg2) cfg2_r <= wdata_s;
    end
  end

  // one odd and one even copy per colour, chosen by the pointer
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int c = 0; c < 3; c++) begin
        odd_pixel_offset_trim_r[c] <= `CCDP_TRIM_RST;
        even_pixel_offset_trim_r[c] <= `CCDP_TRIM_RST;
      end
    end else begin
      if (wr_odd) odd_pixel_offset_trim_r[ptr] <= wdata_s;
      if (wr_even) even_pixel_offset_trim_r[ptr] <= wdata_s;
    end
  end

  // mode from configuration 2: cds bit and mono bit; bayer not sequenced here
  wire mono = cfg2_r[`CCDP_CFG2_MONO_BIT];
  wire cds = cfg2_r[`CCDP_CFG2_CDS_BIT];
  ccdp_mode_e mode;
  assign mode = mono ? (cds ? CCDP_1CH_CDS : CCDP_1CH_SHA)
                     : (cds ? CCDP_3CH_CDS : CCDP_3CH_SHA);

  // colour sequencing and odd/even set tracking
  ccdp_colour_e colour_r, colour_nxt;
  logic odd_set_r, odd_set_nxt;

  always_comb begin
    colour_nxt = colour_r;
    odd_set_nxt = odd_set_r;
    if (!line_start_s) begin
      colour_nxt = CCDP_RED;
      odd_set_nxt = 1'b0;
    end else if (mono) begin
      colour_nxt = ccdp_colour_e'(ptr_ok ? ptr : 2'b00);
      odd_set_nxt = !odd_set_r;
    end else begin
      unique case (colour_r)
        CCDP_RED: colour_nxt = CCDP_GREEN;
        CCDP_GREEN: colour_nxt = CCDP_BLUE;
        CCDP_BLUE: begin
          colour_nxt = CCDP_RED;
          odd_set_nxt = !odd_set_r;
        end
        default: colour_nxt = CCDP_RED;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      colour_r <= CCDP_RED;
      odd_set_r <= 1'b0;
    end else begin
      colour_r <= colour_nxt;
      odd_set_r <= odd_set_nxt;
    end
  end

  // stage 1: odd/even trim on the sampled word
  logic [7:0] trim_sel;
  assign trim_sel = odd_set_r ? odd_pixel_offset_trim_r[colour_r]
                              : even_pixel_offset_trim_r[colour_r];
  // sign-extend and add, one LSB per code
  wire signed [13:0] trim_sum = $signed({2'b00, conv_data_i}) + 14'(signed'(trim_sel));
  logic [11:0] s1_r;

  // words are delayed so they meet the pixel they belong to
  ccdp_words_s words_al;
  ccdp_delay #(.W(22), .D(LW - 1)) u_word_align (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .d_i(words_s), .q_o(words_al));

  // pin distribution from bits 3-5: bit 3 moves two gain lsbs to offset msbs, bit 4 one, bit 5 none; lowest set bit wins
  wire [2:0] pins = cfg_r[`CCDP_CFG_PINS_LSB +: 3];
  wire sub_on = (pins != 3'b000);
  logic [3:0] gain_w;
  logic [3:0] off_w;
  always_comb begin
    gain_w = 4'd12;
    off_w = 4'd8;
    if (pins[0]) begin
      gain_w = 4'd10;
      off_w = 4'd10;
    end else if (pins[1]) begin
      gain_w = 4'd11;
      off_w = 4'd9;
    end else if (pins[2]) begin
      gain_w = 4'd12;
      off_w = 4'd8;
    end
  end
  // offset word occupies the bus width; upper bits beyond its width are ignored
  wire [9:0] off_mask = 10'h3ff >> (4'd10 - off_w);
  wire [9:0] off_word = sub_on ? (words_al.offset & off_mask) : 10'h000;
  wire [11:0] gain_word = words_al.gain >> (4'd12 - gain_w);

  // stage 2: subtract pixel offset, clamp at zero
  wire signed [13:0] diff = $signed({2'b00, s1_r}) - $signed({4'h0, off_word});
  logic [11:0] s2_r;
  logic [11:0] g2_r;

  // gain scale from bits 0-2: full scale 2x, 3x or 5x; bypass if clear
  wire [2:0] scale = cfg_r[`CCDP_CFG_SCALE_LSB +: 3];
  wire mul_on = (scale != 3'b000);
  logic [3:0] extra_shift;
  always_comb begin
    extra_shift = 4'd0;
    if (scale[2]) extra_shift = 4'd2;
    else if (scale[1]) extra_shift = 4'd1;
  end

  // stage 3: multiply; gain = 1 + word/2^(w - shift)
  wire [23:0] prod = 24'(s2_r) * 24'(g2_r);
  wire [4:0] frac_sh = 5'(gain_w) - 5'(extra_shift);
  wire [23:0] scaled = 24'(s2_r) + (prod >> frac_sh);
  logic [11:0] s3_r;
  logic [11:0] s4_r;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r <= '0;
      s2_r <= '0;
      g2_r <= '0;
      s3_r <= '0;
      s4_r <= '0;
    end else begin
      // saturate the trimmed word
      s1_r <= trim_sum[13] ? 12'h000 : (|trim_sum[12:12] ? `CCDP_FULL : trim_sum[11:0]);
      s2_r <= diff[13] ? 12'h000 : diff[11:0];
      g2_r <= gain_word;
      s3_r <= !mul_on ? s2_r : (|scaled[23:12] ? `CCDP_FULL : scaled[11:0]);
      s4_r <= s3_r;
    end
  end

  // pipeline padding so total sample latency is fixed
  logic [11:0] pix_out;
  ccdp_delay #(.W(12), .D(`CCDP_LAT_SAMPLE - 4)) u_out_pad (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .d_i(s4_r), .q_o(pix_out));

  // read-back mux; reserved addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (host_s.addr)
      `CCDP_ADDR_CFG: rd_mux = cfg_r;
      `CCDP_ADDR_CFG2: rd_mux = cfg2_r;
      `CCDP_ADDR_ODD: rd_mux = ptr_ok ? odd_pixel_offset_trim_r[ptr] : 8'h00;
      `CCDP_ADDR_EVEN: rd_mux = ptr_ok ? even_pixel_offset_trim_r[ptr] : 8'h00;
      default: rd_mux = 8'h00;
    endcase
  end

  // bus turns to host port while selected with read strobed; released during writes so the host drives it
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dout_o <= '0;
      dout_oe_o <= '0;
      mux_sel_o <= 2'b00;
      mode_o <= 3'h0;
    end else begin
      if (rd_act) begin
        dout_o <= {4'h0, rd_mux};
        dout_oe_o <= 12'h0ff;
      end else if (wr_act) begin
        dout_o <= '0;
        dout_oe_o <= 12'h000;
      end else begin
        dout_o <= pix_out;
        dout_oe_o <= 12'hfff;
      end
      mux_sel_o <= colour_r;
      mode_o <= mode;
    end
  end
endmodule

//--- ccdp_sequencer_monitor.sv
// port checker for the correction sequencer
`timescale 1ns/1ps
module ccdp_sequencer_monitor (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // watched ports
  input wire logic line_start_i,
  input wire ccdp_pkg::ccdp_host_s host_i,
  input wire logic [11:0] dout_oe_o,
  input wire logic [1:0] mux_sel_o,
  input wire logic [2:0] mode_o
);
  import ccdp_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // line start passes a synchroniser, so it must hold some edges to count
  wire logic rd_w = !host_i.cs_n && !host_i.rd_n;
  wire logic wr_w = !host_i.cs_n && !host_i.wr_n;
  mux_resv_a: assert property (mux_sel_o != 2'h3)
    else $error("mux on reserved code");
  red_green_a: assert property (
    line_start_i [*5] ##0 (mode_o < 3'h2 && mux_sel_o == 2'h0) |=> mux_sel_o == 2'h1)
    else $error("red not followed by green");
  blue_red_a: assert property (mode_o < 3'h2 && mux_sel_o == 2'h2 |=> mux_sel_o == 2'h0)
    else $error("blue not followed by red");
  line_reset_a: assert property (!line_start_i [*5] |-> mux_sel_o == 2'h0)
    else $error("mux off red in line gap");
  read_port_a: assert property (rd_w [*6] |-> dout_oe_o == 12'h0ff)
    else $error("read did not turn bus");
  write_port_a: assert property (wr_w [*6] |-> dout_oe_o == 12'h000)
    else $error("write did not free bus");
  pixel_bus_a: assert property (host_i.cs_n [*8] |-> dout_oe_o == 12'hfff)
    else $error("pixels not driven");
  oe_legal_a: assert property (dout_oe_o inside {12'hfff, 12'h0ff, 12'h000})
    else $error("odd enable pattern");
  cover property (rd_w [*6]);
  cover property (mux_sel_o == 2'h2 ##1 mux_sel_o == 2'h0);
  cover property (line_start_i [*5] ##0 mux_sel_o == 2'h1);
endmodule
bind ccdp_sequencer ccdp_sequencer_monitor mon (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .line_start_i(line_start_i), .host_i(host_i), .dout_oe_o(dout_oe_o),
  .mux_sel_o(mux_sel_o), .mode_o(mode_o));

//--- ccdp_sync.sv
// two-flop synchroniser for a pin level
`timescale 1ns/1ps
module ccdp_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end
  assign q_o = sync_r;
endmodule

//--- tb_ccdp_sequencer.sv
// self-checking bench for the correction sequencer
`timescale 1ns/1ps
`include "ccdp_regs.svh"
module tb_ccdp_sequencer;
  import ccdp_pkg::*;
  logic clk_sys_i, resetn_i, line_w, line_start_i;
  logic [11:0] conv_w, conv_data_i, dout_o, dout_oe_o, rq;
  logic [7:0] host_d, host_register_data_i;
  logic [1:0] mux_sel_o;
  logic [2:0] mode_o;
  ccdp_words_s words_w, words_i;
  ccdp_host_s host_i;
  int n_errors, compares;
  // config, trim, converter, gain, offset, expected pixel
  logic [63:0] rows [14] = '{64'h00_7f_100_000_000_17f, 64'h00_01_100_000_000_101,
    64'h00_00_100_000_000_100, 64'h00_ff_100_000_000_0ff, 64'h00_80_100_000_000_080,
    64'h00_80_050_000_000_000, 64'h00_7f_ff0_000_000_fff, 64'h08_00_500_000_3ff_101,
    64'h08_00_100_000_3ff_000, 64'h01_00_400_800_000_600, 64'h01_00_c00_800_000_fff,
    64'h02_00_300_800_000_600, 64'h04_00_300_400_000_600, 64'h01_7f_181_800_000_300};
  // shared pin: the host value shows only while the device lets go
  assign host_register_data_i = dout_oe_o[0] ? dout_o[7:0] : host_d;
  ccdp_scanner_model scanner (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .line_i(line_w),
    .conv_i(conv_w), .words_i(words_w), .line_start_o(line_start_i),
    .conv_data_o(conv_data_i), .words_o(words_i));
  ccdp_sequencer dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .conv_data_i(conv_data_i),
    .line_start_i(line_start_i), .words_i(words_i), .host_i(host_i),
    .host_register_data_i(host_register_data_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .mux_sel_o(mux_sel_o), .mode_o(mode_o));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // strobes held six edges: the pins are synchronised before use
  task automatic host_op(input logic wr, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    host_i <= {1'b0, !wr, wr, a};
    host_d <= d;
    repeat (5) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rq = dout_o;
    @(posedge clk_sys_i);
    host_i <= {3'b111, a};
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic look(input logic [11:0] exp);
    repeat (14) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check(dout_o, exp);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_errors++;
    complete_run();
  end
  initial begin
    n_errors = 0;
    compares = 0;
    resetn_i = 1'b0;
    line_w = 1'b0;
    conv_w = 12'h123;
    words_w = '0;
    host_i = 6'h38;
    host_d = 8'h00;
    repeat (16) @(posedge clk_sys_i);
    check(dout_o, 12'h000);
    resetn_i <= 1'b1;
    look(12'h123);
    check({9'h0, mode_o}, 12'h001);
    host_op(1'b1, `CCDP_ADDR_CFG2, 8'h01);
    look(12'h123);
    check({9'h0, mode_o}, 12'h000);
    foreach (rows[i]) begin
      host_op(1'b1, `CCDP_ADDR_CFG, rows[i][63:56]);
      host_op(1'b1, `CCDP_ADDR_EVEN, rows[i][55:48]);
      conv_w <= rows[i][47:36];
      words_w <= {rows[i][35:24], rows[i][21:12]};
      look(rows[i][11:0]);
    end
    host_op(1'b1, `CCDP_ADDR_EVEN, 8'h00);
    host_op(1'b1, `CCDP_ADDR_CFG, 8'h08);
    conv_w <= 12'h500;
    words_w <= '0;
    look(12'h500);
    @(posedge clk_sys_i);
    conv_w <= 12'h600;
    repeat (7) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check(dout_o, 12'h500);
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check(dout_o, 12'h600);
    @(posedge clk_sys_i);
    words_w <= {12'h000, 10'h100};
    repeat (10) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check(dout_o, 12'h600);
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check(dout_o, 12'h500);
    conv_w <= 12'h100;
    words_w <= '0;
    for (int c = 0; c < 3; c++) begin
      host_op(1'b1, `CCDP_ADDR_CFG, {c[1:0], 6'h00});
      host_op(1'b1, `CCDP_ADDR_EVEN, 8'(c + 1));
      host_op(1'b1, `CCDP_ADDR_ODD, 8'(c + 4));
    end
    host_op(1'b0, `CCDP_ADDR_ODD, 8'h00);
    check({4'h0, rq[7:0]}, 12'h006);
    host_op(1'b0, `CCDP_ADDR_EVEN, 8'h00);
    check({4'h0, rq[7:0]}, 12'h003);
    host_op(1'b0, 3'h2, 8'h00);
    check({4'h0, rq[7:0]}, 12'h000);
    // reserved pointer: this trim write must land nowhere
    host_op(1'b1, `CCDP_ADDR_CFG, 8'hc0);
    host_op(1'b1, `CCDP_ADDR_EVEN, 8'h7f);
    look(12'h101);
    @(posedge clk_sys_i);
    line_w <= 1'b1;
    for (int k = 0; k < 40 && dout_o === 12'h101; k++) @(negedge clk_sys_i);
    for (int k = 0; k < 6; k++) begin
      check(dout_o, k == 5 ? 12'h101 : 12'h102 + 12'(k));
      @(negedge clk_sys_i);
    end
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    line_w <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    look(12'h100);
    complete_run();
  end
endmodule
